// ===== core/i2sf_pkg.sv
// Constants and types shared by the I2C status-flag block
// Summary of operation
// - Bus status register is read only, as a whole byte or single bits.
// - Reset clears every bit of the bus status register.
// - Bit order 7..0: master, arb lost, ext code, match, dir, ack, start, stop.
// - Master-active flag sets when this device generates a start condition.
// - Master-active clears on stop, arb loss, release, enable off, reset.
// - Arbitration loss sets arb-lost flag and clears master-active flag.
// - Arb-lost clears on status read, enable falling, and reset.
// - Single-bit access to any other status bit also clears arb-lost.
// - Eighth clock of address byte sets ext-code when top nibble 0000 or 1111.
// - Ext-code clears on start, stop, release, enable falling, reset.
// - Eighth clock sets address-match when address equals local slave address.
// - Address-match clears on start, stop, release, enable falling, reset.
// - With direction flag zero the data line is released, high impedance, except while this device generates a start.
package i2sf_pkg;

  localparam int          IDX_W          = 28;
  // Status index as printed; byte address is four times the index
  localparam logic [27:0] STATUS_IDX     = 28'hFFFFD86;
  localparam logic [27:0] CTRL_IDX       = 28'hFFFFD90;
  localparam logic [27:0] SVA_IDX        = 28'hFFFFD91;
  localparam logic [27:0] INT_STAT_IDX   = 28'hFFFFD92;
  localparam logic [27:0] INT_MASK_IDX   = 28'hFFFFD93;
  localparam logic [27:0] BIT_VIEW_IDX   = 28'hFFFFD98;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  SVA_RESET      = 8'h00;
  localparam logic [3:0]  INT_RESET      = 4'h0;

  // Status bit positions
  localparam int          ST_MASTER      = 7;
  localparam int          ST_ARB_LOST    = 6;
  localparam int          ST_EXT_CODE    = 5;
  localparam int          ST_ADDR_MATCH  = 4;
  localparam int          ST_DIR         = 3;
  localparam int          ST_ACK         = 2;
  localparam int          ST_START       = 1;
  localparam int          ST_STOP        = 0;

  // Control bit positions
  localparam int          CT_ENABLE      = 0;
  localparam int          CT_START_TRIG  = 1;
  localparam int          CT_RELEASE     = 2;

  // Interrupt status and mask bit positions
  localparam int          IN_START       = 0;
  localparam int          IN_STOP        = 1;
  localparam int          IN_ARB_LOST    = 2;
  localparam int          IN_ADDR_MATCH  = 3;

  localparam logic [3:0]  BIT_ADDR_LAST  = 4'h8;
  localparam logic [3:0]  BIT_ACK        = 4'h9;
  localparam logic [3:0]  EXT_LOW        = 4'h0;
  localparam logic [3:0]  EXT_HIGH       = 4'hF;

  typedef enum logic [1:0] {
    I2SF_GEN_IDLE  = 2'b01,
    I2SF_GEN_DRIVE = 2'b10
  } i2sf_gen_t;

endpackage : i2sf_pkg

// ===== core/i2sf_sync.sv
// Two-flop synchroniser for pins sampled by the core clock
`timescale 1ns/1ps
`default_nettype none
module i2sf_sync #(
  parameter int          WIDTH = 2,
  parameter logic [1:0]  INIT  = 2'h3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Idle bus lines are high, so the flops reset high to avoid a false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{INIT[0]}};
      q      <= {WIDTH{INIT[0]}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : i2sf_sync
`default_nettype wire

// ===== core/i2sf_status.sv
// I2C bus status flags with APB register access and interrupt
`timescale 1ns/1ps
`default_nettype none
module i2sf_status (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  input  wire logic        tx_bit,
  output logic             irq
);

  typedef struct packed {
    logic            enable;
    logic            start_trig;
    logic [7:0]      sva;
    logic            master_active_flag;
    logic            arbitration_lost_flag;
    logic            extension_code_flag;
    logic            address_match_flag;
    logic            transmit_receive_direction;
    logic            acknowledge_detected_flag;
    logic            start_detected_flag;
    logic            stop_detected_flag;
    logic            scl_prev;
    logic            sda_prev;
    logic            busy;
    logic [3:0]      bit_cnt;
    logic [7:0]      shift;
    logic            first_byte;
    logic            read_req;
    i2sf_pkg::i2sf_gen_t gen;
    logic [3:0]      int_stat;
    logic [3:0]      int_mask;
    logic [31:0]     rdata;
    logic            rd_err;
    logic            ald_seen;
  } i2sf_state_t;

  i2sf_state_t s_q;
  i2sf_state_t s_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;

  // Reset asserts at once and releases through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  i2sf_sync #(
    .WIDTH (2),
    .INIT  (2'h3)
  ) u_pin_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({scl_in, serial_data_line_in}),
    .q     (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  function automatic logic hit(input logic [31:0] addr, input logic [27:0] idx);
    hit = (addr == {2'h0, idx, 2'h0});
  endfunction : hit

  function automatic logic [7:0] status_byte(input i2sf_state_t s);
    status_byte = {s.master_active_flag, s.arbitration_lost_flag,
                   s.extension_code_flag, s.address_match_flag,
                   s.transmit_receive_direction, s.acknowledge_detected_flag,
                   s.start_detected_flag, s.stop_detected_flag};
  endfunction : status_byte

  logic       setup_ph;
  logic       access_ph;
  logic       wr_acc;
  logic       rd_acc;
  logic       bit_view;
  logic       mapped;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;
  logic       release_cmd;
  logic       en_fall;
  logic       arb_lost;
  logic       own_start;
  logic       byte_done;
  logic       ack_edge;
  logic       comm_clear;
  logic [3:0] int_evt;
  logic [7:0] st_byte;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = access_ph;
  assign st_byte   = status_byte(s_q);
  assign wr_acc    = access_ph & pwrite;
  assign rd_acc    = access_ph & ~pwrite;
  assign bit_view  = (paddr[31:5] == {2'h0, i2sf_pkg::BIT_VIEW_IDX[27:3]}) && (paddr[1:0] == 2'h0);
  assign mapped    = hit(paddr, i2sf_pkg::STATUS_IDX) | hit(paddr, i2sf_pkg::CTRL_IDX)
                   | hit(paddr, i2sf_pkg::SVA_IDX) | hit(paddr, i2sf_pkg::INT_STAT_IDX)
                   | hit(paddr, i2sf_pkg::INT_MASK_IDX) | bit_view;

  // Bus conditions seen on the synchronised lines, only while enabled
  assign scl_rise  = s_q.enable & ~s_q.scl_prev & scl_s;
  assign scl_fall  = s_q.enable & s_q.scl_prev & ~scl_s;
  assign start_det = s_q.enable & s_q.scl_prev & scl_s & s_q.sda_prev & ~sda_s;
  assign stop_det  = s_q.enable & s_q.scl_prev & scl_s & ~s_q.sda_prev & sda_s;

  assign release_cmd = wr_acc & hit(paddr, i2sf_pkg::CTRL_IDX) & pwdata[i2sf_pkg::CT_RELEASE];
  assign en_fall     = s_q.enable & wr_acc & hit(paddr, i2sf_pkg::CTRL_IDX) & ~pwdata[i2sf_pkg::CT_ENABLE];
  assign comm_clear  = release_cmd | en_fall;
  assign own_start   = start_det & (s_q.gen == i2sf_pkg::I2SF_GEN_DRIVE);

  // A master sending a one that samples zero has lost the bus
  assign arb_lost  = scl_rise & s_q.master_active_flag & s_q.transmit_receive_direction
                   & tx_bit & ~sda_s & (s_q.bit_cnt != (i2sf_pkg::BIT_ACK - 4'h1));
  assign byte_done = scl_rise & s_q.busy & (s_q.bit_cnt == i2sf_pkg::BIT_ADDR_LAST - 4'h1);
  assign ack_edge  = scl_rise & s_q.busy & (s_q.bit_cnt == i2sf_pkg::BIT_ACK - 4'h1);

  always_comb begin
    s_d          = s_q;
    s_d.scl_prev = scl_s;
    s_d.sda_prev = sda_s;

    // Control writes; the status register takes no writes
    if (wr_acc && hit(paddr, i2sf_pkg::CTRL_IDX)) begin
      s_d.enable = pwdata[i2sf_pkg::CT_ENABLE];
      if (pwdata[i2sf_pkg::CT_START_TRIG]) begin
        s_d.start_trig = 1'b1;
      end
    end
    if (wr_acc && hit(paddr, i2sf_pkg::SVA_IDX)) begin
      s_d.sva = pwdata[7:0];
    end
    if (wr_acc && hit(paddr, i2sf_pkg::INT_MASK_IDX)) begin
      s_d.int_mask = pwdata[3:0];
    end

    // Bus framing and bit counting
    if (start_det) begin
      s_d.busy       = 1'b1;
      s_d.bit_cnt    = 4'h0;
      s_d.first_byte = 1'b1;
    end else if (stop_det || !s_q.enable) begin
      s_d.busy       = 1'b0;
      s_d.bit_cnt    = 4'h0;
      s_d.first_byte = 1'b0;
    end else if (scl_rise && s_q.busy) begin
      if (ack_edge) begin
        s_d.bit_cnt    = 4'h0;
        s_d.first_byte = 1'b0;
      end else begin
        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        s_d.shift   = {s_q.shift[6:0], sda_s};
      end
    end

    // Start generation: hold the data line low until the clock falls
    unique case (s_q.gen)
      i2sf_pkg::I2SF_GEN_IDLE: begin
        if (s_q.enable && s_q.start_trig && !s_q.busy && scl_s) begin
          s_d.gen = i2sf_pkg::I2SF_GEN_DRIVE;
        end
      end
      i2sf_pkg::I2SF_GEN_DRIVE: begin
        if (scl_fall || !s_q.enable || release_cmd) begin
          s_d.gen = i2sf_pkg::I2SF_GEN_IDLE;
        end
      end
    endcase
    if (own_start || arb_lost || comm_clear) begin
      s_d.start_trig = 1'b0;
    end

    // Start and stop detected flags
    if (start_det) begin
      s_d.start_detected_flag = 1'b1;
      s_d.stop_detected_flag  = 1'b0;
    end else if (stop_det) begin
      s_d.start_detected_flag = 1'b0;
      s_d.stop_detected_flag  = 1'b1;
    end
    if (comm_clear) begin
      s_d.start_detected_flag = 1'b0;
    end
    if (en_fall) begin
      s_d.stop_detected_flag = 1'b0;
    end

    // Master-active
    if (stop_det || arb_lost || comm_clear) begin
      s_d.master_active_flag = 1'b0;
    end else if (own_start) begin
      s_d.master_active_flag = 1'b1;
    end

    // Extension code and address match, cleared by framing or release
    if (start_det || stop_det || comm_clear) begin
      s_d.extension_code_flag = 1'b0;
      s_d.address_match_flag  = 1'b0;
    end
    if (byte_done && s_q.first_byte) begin
      if (s_q.shift[6:3] == i2sf_pkg::EXT_LOW
          || s_q.shift[6:3] == i2sf_pkg::EXT_HIGH) begin
        s_d.extension_code_flag = 1'b1;
      end
      if ({s_q.shift[6:0]} == s_q.sva[7:1]) begin
        s_d.address_match_flag = 1'b1;
      end
      s_d.read_req = sda_s;
    end

    // Direction: master sends its address, then follows the read bit
    if (start_det || stop_det || comm_clear || arb_lost) begin
      s_d.transmit_receive_direction = own_start;
    end else if (ack_edge && s_q.first_byte) begin
      if (s_q.master_active_flag) begin
        s_d.transmit_receive_direction = ~s_q.read_req;
      end else begin
        s_d.transmit_receive_direction = s_q.address_match_flag & s_q.read_req;
      end
    end

    // Acknowledge seen on the ninth clock
    if (start_det || stop_det || comm_clear) begin
      s_d.acknowledge_detected_flag = 1'b0;
    end else if (ack_edge) begin
      s_d.acknowledge_detected_flag = ~sda_s;
    end

    // Read data captured in the setup phase
    if (setup_ph) begin
      s_d.rdata    = 32'h0000_0000;
      s_d.rd_err   = ~mapped;
      s_d.ald_seen = 1'b0;
      if (hit(paddr, i2sf_pkg::STATUS_IDX)) begin
        s_d.rdata    = {24'h00_0000, status_byte(s_q)};
        s_d.ald_seen = s_q.arbitration_lost_flag;
      end else if (bit_view) begin
        s_d.rdata    = {31'h0000_0000, st_byte[paddr[4:2]]};
        s_d.ald_seen = s_q.arbitration_lost_flag;
      end else if (hit(paddr, i2sf_pkg::CTRL_IDX)) begin
        s_d.rdata = {29'h0000_0000, 1'b0, s_q.start_trig, s_q.enable};
      end else if (hit(paddr, i2sf_pkg::SVA_IDX)) begin
        s_d.rdata = {24'h00_0000, s_q.sva};
      end else if (hit(paddr, i2sf_pkg::INT_STAT_IDX)) begin
        s_d.rdata = {28'h000_0000, s_q.int_stat};
      end else if (hit(paddr, i2sf_pkg::INT_MASK_IDX)) begin
        s_d.rdata = {28'h000_0000, s_q.int_mask};
      end
    end

    // Arb-lost: cleared only if it was shown, so a fresh loss survives
    if (rd_acc && (hit(paddr, i2sf_pkg::STATUS_IDX) || bit_view) && s_q.ald_seen) begin
      s_d.arbitration_lost_flag = 1'b0;
    end
    if (en_fall) begin
      s_d.arbitration_lost_flag = 1'b0;
    end
    if (arb_lost) begin
      s_d.arbitration_lost_flag = 1'b1;
    end

    // Sticky interrupt causes; read clears what was shown, new events win
    if (rd_acc && hit(paddr, i2sf_pkg::INT_STAT_IDX)) begin
      s_d.int_stat = s_q.int_stat & ~s_q.rdata[3:0];
    end
    s_d.int_stat = s_d.int_stat | int_evt;
  end

  always_comb begin
    int_evt = 4'h0;
    int_evt[i2sf_pkg::IN_START]      = start_det;
    int_evt[i2sf_pkg::IN_STOP]       = stop_det;
    int_evt[i2sf_pkg::IN_ARB_LOST]   = arb_lost;
    int_evt[i2sf_pkg::IN_ADDR_MATCH] = byte_done & s_q.first_byte & (s_q.shift[6:0] == s_q.sva[7:1]);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q                            <= '0;
      s_q.sva                        <= i2sf_pkg::SVA_RESET;
      s_q.scl_prev                   <= 1'b1;
      s_q.sda_prev                   <= 1'b1;
      s_q.gen                        <= i2sf_pkg::I2SF_GEN_IDLE;
      s_q.int_stat                   <= i2sf_pkg::INT_RESET;
      s_q.int_mask                   <= i2sf_pkg::INT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.rdata;
  assign pslverr = access_ph & s_q.rd_err;
  assign irq     = |(s_q.int_stat & s_q.int_mask);

  // Open drain: only ever pull low; released whenever not transmitting or generating a start
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe  = (s_q.gen == i2sf_pkg::I2SF_GEN_DRIVE)
                              | (s_q.transmit_receive_direction & ~tx_bit & s_q.busy
                                 & ~scl_s);

endmodule : i2sf_status
`default_nettype wire

// ===== verif/i2sf_status_checker.sv
// Port-level assertions for the status-flag block
`timescale 1ns/1ps
`default_nettype none
module i2sf_status_checker (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_data_line_out,
  input wire logic        serial_data_line_oe,
  input wire logic        irq
);
  localparam logic [31:0] ST_A = {2'h0, i2sf_pkg::STATUS_IDX, 2'h0};
  localparam logic [31:0] BV_A = {2'h0, i2sf_pkg::BIT_VIEW_IDX, 2'h0};
  logic acc;
  logic rd_st;
  logic rd_bv;
  assign acc   = psel && penable;
  assign rd_st = acc && !pwrite && paddr == ST_A;
  assign rd_bv = acc && !pwrite && paddr >= BV_A && paddr <= BV_A + 32'h1C;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_st_ok; acc && paddr == ST_A |-> pready && !pslverr; endproperty
  a_st_ok: assert property (p_st_ok) else $error("status access not answered cleanly");
  property p_rd_byte; rd_st |-> prdata[31:8] == 24'h0; endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("status read wider than a byte");
  property p_rd_bit; rd_bv |-> prdata[31:1] == 31'h0 && !pslverr; endproperty
  a_rd_bit: assert property (p_rd_bit) else $error("single-bit read wider than a bit");
  property p_rst;
    disable iff (1'b0) !rst_b && $past(!rst_b) |-> prdata == 32'h0 && !irq && !serial_data_line_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
  property p_ald_clr; rd_st && prdata[6] |-> ##2 (rd_st -> !prdata[6]); endproperty
  a_ald_clr: assert property (p_ald_clr) else $error("arbitration flag survived a read");
  property p_ald_mst; rd_st && prdata[6] |-> !prdata[7]; endproperty
  a_ald_mst: assert property (p_ald_mst) else $error("master flag set with arbitration lost");
  property p_idle_hiz; rd_st && prdata[7:2] == 6'h0 |-> !serial_data_line_oe; endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("data line driven while receiving");
  property p_out_low; serial_data_line_oe |-> !serial_data_line_out; endproperty
  a_out_low: assert property (p_out_low) else $error("data line driven high");
  c_ald: cover property (rd_st && prdata[6]);
  c_oe: cover property (serial_data_line_oe);
  c_irq: cover property (irq);
endmodule : i2sf_status_checker
bind i2sf_status i2sf_status_checker i2sf_status_checker_i (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe));
`default_nettype wire

// ===== verif/i2sf_bus_model.sv
// Open-drain bus partner: another master that clocks the link
`timescale 1ns/1ps
`default_nettype none
module i2sf_bus_model (
  output var logic scl_oe,
  output var logic sda_oe
);
  // Clock released between frames, so it stands high outside them
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic start_cond();
    sda_oe <= 1'b1;
    #40;
  endtask : start_cond
  // One 80 ns bit; ends with the clock high
  task automatic put_bit(input logic b);
    scl_oe <= 1'b1;
    #10 sda_oe <= !b;
    #30 scl_oe <= 1'b0;
    #40;
  endtask : put_bit
  // Ninth clock released so the addressed device may acknowledge
  task automatic put_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    put_bit(1'b1);
  endtask : put_byte
  task automatic stop_cond();
    scl_oe <= 1'b1;
    sda_oe <= 1'b1;
    #20 scl_oe <= 1'b0;
    #20 sda_oe <= 1'b0;
    #40;
  endtask : stop_cond
endmodule : i2sf_bus_model
`default_nettype wire

// ===== verif/i2sf_status_tb_top.sv
// Self-checking bench: register reads, bus frames, arbitration, interrupt
`timescale 1ns/1ps
`default_nettype none
module i2sf_status_tb_top;
  localparam logic [31:0] ST_A = {2'h0, i2sf_pkg::STATUS_IDX, 2'h0};
  localparam logic [31:0] CT_A = {2'h0, i2sf_pkg::CTRL_IDX, 2'h0};
  localparam logic [31:0] SV_A = {2'h0, i2sf_pkg::SVA_IDX, 2'h0};
  localparam logic [31:0] IS_A = {2'h0, i2sf_pkg::INT_STAT_IDX, 2'h0};
  localparam logic [31:0] IM_A = {2'h0, i2sf_pkg::INT_MASK_IDX, 2'h0};
  localparam logic [31:0] BV_A = {2'h0, i2sf_pkg::BIT_VIEW_IDX, 2'h0};
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic        sdo, sd_oe, tx_bit, m_scl_oe, m_sda_oe, scl, sda;
  logic [31:0] paddr, pwdata, prdata;
  logic [65:0] note_q[$];
  logic [65:0] n;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  // Open-drain wires with pull-ups
  assign scl = !m_scl_oe;
  assign sda = !m_sda_oe && (!sd_oe || sdo);
  i2sf_status i2sf_status_i (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .serial_data_line_in(sda), .serial_data_line_out(sdo),
    .serial_data_line_oe(sd_oe), .tx_bit(tx_bit), .irq(irq));
  i2sf_bus_model i2sf_bus_model_i (.scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // Keep leaves the select up so the next setup follows at once
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input bit keep);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!keep) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [32:0] e, input logic [32:0] m, input bit keep = 1'b0);
    note_q.push_back({m, e & m});
    apb(1'b0, a, 32'h0, keep);
  endtask : rd
  function automatic logic [32:0] sm(input logic [7:0] b);
    return {25'h1FFFFFF, b};
  endfunction : sm
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = note_q.pop_front();
      check($sformatf("read %h", paddr), {pslverr, prdata} & n[65:33], n[32:0]);
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    logic [7:0] sva;
    logic [7:0] adr;
    logic [7:0] ex;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    tx_bit = 1'b0;
    void'($urandom(32'h5279));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(ST_A, 33'h0, 33'h1FFFFFFFF);
    wr(ST_A, 32'hFF);
    rd(ST_A, 33'h0, 33'h1FFFFFFFF);
    rd(32'h0, 33'h100000000, 33'h100000000);
    wr(CT_A, 32'h1);
    sva = 8'($urandom);
    wr(SV_A, {24'h0, sva});
    for (int k = 0; k < 4; k++) begin
      adr = (k == 0) ? sva : (k == 1) ? 8'h00 : (k == 2) ? 8'hF4 : 8'($urandom);
      adr[0] = 1'b0;
      ex = {2'b00, adr[7:4] == 4'h0 || adr[7:4] == 4'hF, adr[7:1] == sva[7:1], 4'b0010};
      i2sf_bus_model_i.start_cond();
      i2sf_bus_model_i.put_byte(adr);
      repeat (5) @(posedge core_clk);
      rd(ST_A, {25'h0, ex}, sm(8'hF3));
      if (k == 1 || k == 2) begin
        wr(CT_A, k == 1 ? 32'h5 : 32'h0);
        rd(ST_A, 33'h0, sm(8'hF3));
      end
      i2sf_bus_model_i.stop_cond();
      repeat (5) @(posedge core_clk);
      rd(ST_A, {32'h0, 1'(k != 2)}, sm(8'hF3));
      wr(CT_A, 32'h1);
    end
    for (int r = 0; r < 2; r++) begin
      wr(IM_A, {29'h0, r[0], 2'h0});
      tx_bit <= 1'b1;
      wr(CT_A, 32'h3);
      repeat (6) @(posedge core_clk);
      rd(ST_A, 33'h80, sm(8'hC0));
      i2sf_bus_model_i.put_bit(1'b0);
      repeat (5) @(posedge core_clk);
      check("irq", {32'h0, irq}, {32'h0, r[0]});
      if (r == 0) rd(ST_A, 33'h40, sm(8'hC0), 1'b1);
      else rd(BV_A + 32'h1C, 33'h0, 33'h1FFFFFFFF, 1'b1);
      rd(ST_A, 33'h0, sm(8'h40));
      rd(IS_A, 33'h4, 33'h4);
      check("irq", {32'h0, irq}, 33'h0);
      i2sf_bus_model_i.stop_cond();
      repeat (5) @(posedge core_clk);
    end
    results();
  end
endmodule : i2sf_status_tb_top
`default_nettype wire
